/* rtl/scss_pkg.sv */
// constants, types and register map of the system clock source selector
// assumes a single 250 MHz reference clock drives all logic
package scss_pkg;

  // ==========================================================
  // timing
  localparam int CLK_KHZ      = 250000;                  // reference clock rate
  localparam int MF_KHZ       = 500;                     // mid oscillator rate
  localparam int LF_KHZ       = 31;                      // low oscillator rate
  localparam int PLL_SHIFT    = 5;                       // pll multiplies by 32
  localparam int MF_HALF_CYC  = CLK_KHZ / (2 * MF_KHZ);  // 250
  localparam int LF_HALF_CYC  = CLK_KHZ / (2 * LF_KHZ);  // 4032
  localparam int HALF_W       = 13;
  localparam int HF_START_CYC = 64;
  localparam int MF_START_CYC = 128;
  localparam int LF_START_CYC = 32;

  // ==========================================================
  // register map
  localparam logic [7:0]  ADR_CTRL      = 8'h00;
  localparam logic [7:0]  ADR_STAT      = 8'h04;
  localparam logic [7:0]  ADR_TRIM      = 8'h08;
  localparam logic [7:0]  ADR_CFG       = 8'h0c;
  localparam int          CTRL_SCS_LSB  = 0;
  localparam int          CTRL_IRCF_LSB = 3;
  localparam logic [1:0]  SCS_RST       = 2'h0;
  localparam logic [3:0]  IRCF_RST      = 4'h7;
  localparam logic [5:0]  TRIM_RST      = 6'h00;
  localparam int          STAT_SRC_LSB  = 4;
  localparam int          STAT_BUSY_BIT = 6;
  localparam logic [3:0]  IRCF_MF_MIN   = 4'h2;
  localparam logic [3:0]  IRCF_HF_MIN   = 4'h8;

  // ==========================================================
  // encodings
  typedef enum logic [2:0] {
    FOSC_LP = 3'b000, FOSC_XT = 3'b001, FOSC_HS = 3'b010, FOSC_RC = 3'b011,
    FOSC_INT = 3'b100, FOSC_ECL = 3'b101, FOSC_ECM = 3'b110, FOSC_ECH = 3'b111
  } scss_fosc_t;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00, SRC_LF = 2'b01, SRC_MF = 2'b10, SRC_HF = 2'b11
  } scss_src_t;

  localparam logic [1:0] EC_PWR_OFF  = 2'h0;
  localparam logic [1:0] EC_PWR_LOW  = 2'h1;
  localparam logic [1:0] EC_PWR_MED  = 2'h2;
  localparam logic [1:0] EC_PWR_HIGH = 2'h3;

endpackage

/* rtl/scss_osc.sv */
// one internal oscillator model: start-up delay, then a square wave
// assumes i_half is at least 2 and stays steady while running
`timescale 1ns/1ps
module scss_osc
  import scss_pkg::*;
#(
  parameter int START_CYC = 64,
  parameter int HW        = HALF_W
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_en,
  input  wire logic [HW-1:0] i_half,
  output logic               o_ready,
  output logic               o_lvl
);

  localparam int SW = $clog2(START_CYC + 1);
  localparam logic [SW-1:0] START_LAST = SW'(START_CYC - 1);

  logic [SW-1:0] st_cnt;
  logic [HW-1:0] ph;

  // ==========================================================
  // start-up counter, restarts whenever shut down
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_cnt  <= '0;
      o_ready <= 1'b0;
    end else if (!i_en) begin
      st_cnt  <= '0;
      o_ready <= 1'b0;
    end else if (!o_ready) begin
      if (st_cnt == START_LAST) o_ready <= 1'b1;
      st_cnt <= st_cnt + 1'b1;
    end
  end

  // ==========================================================
  // half-period counter toggles the output level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph    <= '0;
      o_lvl <= 1'b0;
    end else if (!o_ready) begin
      ph    <= '0;
      o_lvl <= 1'b0;
    end else if (ph >= i_half - 1'b1) begin
      ph    <= '0;
      o_lvl <= ~o_lvl;
    end else begin
      ph <= ph + 1'b1;
    end
  end

  a_osc_shutdown: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_en |=> !o_ready) else $error("oscillator ready while shut down");

endmodule // scss_osc

/* rtl/scss_switch.sv */
// glitch-free hand-over between two clock levels
// assumes both levels are sampled on i_clk and start is a one-cycle pulse
`timescale 1ns/1ps
module scss_switch (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_cur_lvl,
  input  wire logic i_new_lvl,
  output logic      o_hold,
  output logic      o_done
);

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00, SW_FALL = 2'b01, SW_RISE = 2'b10
  } scss_sw_t;

  scss_sw_t sw_st;
  logic     cur_d;
  logic     new_d;

  // ==========================================================
  // edge history of both clocks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_d <= 1'b0;
      new_d <= 1'b0;
    end else begin
      cur_d <= i_cur_lvl;
      new_d <= i_new_lvl;
    end
  end

  // ==========================================================
  // wait old fall, hold low, wait new rise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_st  <= SW_IDLE;
      o_hold <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (sw_st)
        SW_IDLE: begin
          if (i_start) sw_st <= SW_FALL;
        end
        SW_FALL: begin
          if (cur_d && !i_cur_lvl) begin
            o_hold <= 1'b1;
            sw_st  <= SW_RISE;
          end
        end
        SW_RISE: begin
          if (!new_d && i_new_lvl) begin
            o_hold <= 1'b0;
            o_done <= 1'b1;
            sw_st  <= SW_IDLE;
          end
        end
        default: sw_st <= SW_IDLE;
      endcase
    end
  end

  a_done_after_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> $past(o_hold)) else $error("switch done without hold phase");

endmodule // scss_switch

/* rtl/scss_top.sv */
// system clock source selector with wishbone register access
// assumes configuration straps are steady at reset release and pins are asynchronous
`timescale 1ns/1ps

// What this block does
// - decode 3-bit oscillator configuration into modes
// - internal mode frees clock input for GPIO
// - in RC and internal modes, clock output enable picks clock_output_pin or GPIO
// - RC mode leaves second pin free
// - configured source is default after reset
// - select field switches to internal oscillator
// - exactly one of three internal sources presented
// - high clock multiplied from mid oscillator
// - trim register adjusts high and mid
// - low oscillator nominally 31 kHz source
// - stopped target oscillator runs start-up delay
// - status shows active internal oscillators
// - fall, hold low, new rise, then status
// - same source change skips start-up delay
module scss_top
  import scss_pkg::*;
#(
  parameter int HF_START = HF_START_CYC,
  parameter int MF_START = MF_START_CYC,
  parameter int LF_START = LF_START_CYC
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESET,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic [2:0]  I_OSC_CONFIG,
  input  wire logic        I_CLOCK_OUTPUT_PIN_PIN_EN,
  input  wire logic        I_CLOCK_INPUT_PIN,
  input  wire logic        I_OSCILLATOR_PIN_TWO_GPIO_OUT,
  input  wire logic        I_OSCILLATOR_PIN_TWO_GPIO_OE,
  output logic             O_SYS_CLK,
  output logic             O_CLOCK_INPUT_PIN_GPIO_EN,
  output logic             O_OSCILLATOR_PIN_TWO_OUT,
  output logic             O_OSCILLATOR_PIN_TWO_OE,
  output logic             O_XTAL_EN,
  output logic      [1:0]  O_EC_POWER
);

  typedef enum logic [2:0] {
    ST_INIT = 3'b000, ST_BOOT = 3'b001, ST_IDLE = 3'b010,
    ST_START = 3'b011, ST_SWITCH = 3'b100
  } scss_state_t;

  scss_state_t    state;
  scss_fosc_t     fosc;
  logic           clock_output_pin_en;
  logic           cfg_done;
  logic [1:0]     scs;
  logic [3:0]     ircf;
  logic [5:0]     trim;
  scss_src_t      cur_src;
  scss_src_t      nxt_src;
  scss_src_t      stat_src;
  scss_src_t      tgt_src;
  scss_src_t      int_src;
  logic           run;
  logic           sw_start;
  logic           sw_hold;
  logic           sw_done;
  logic [2:0]     osc_en;
  logic           lf_rdy, mf_rdy, hf_rdy;
  logic           lf_lvl, mf_lvl, hf_lvl;
  logic           clock_input_pin_s1, clock_input_pin_s2, clock_input_pin_s3;
  logic           ext_lvl;
  logic [2:0]     stat_rdy;
  logic [HALF_W-1:0] mf_half;
  logic [HALF_W-1:0] hf_half;
  logic           wb_req;
  logic           next_sys;
  logic           rc_or_int;

  // ==========================================================
  // clock input pin synchroniser, level moves once stages 2 and 3 agree
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      clock_input_pin_s1 <= 1'b0;
      clock_input_pin_s2 <= 1'b0;
      clock_input_pin_s3 <= 1'b0;
      ext_lvl  <= 1'b0;
    end else begin
      clock_input_pin_s1 <= I_CLOCK_INPUT_PIN;
      clock_input_pin_s2 <= clock_input_pin_s1;
      clock_input_pin_s3 <= clock_input_pin_s2;
      if (clock_input_pin_s2 == clock_input_pin_s3) ext_lvl <= clock_input_pin_s3;
    end
  end

  // ==========================================================
  // strap capture after reset release
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      fosc      <= FOSC_LP;
      clock_output_pin_en <= 1'b0;
      cfg_done  <= 1'b0;
    end else if (!cfg_done) begin
      fosc      <= scss_fosc_t'(I_OSC_CONFIG);
      clock_output_pin_en <= I_CLOCK_OUTPUT_PIN_PIN_EN;
      cfg_done  <= 1'b1;
    end
  end

  // ==========================================================
  // target source: frequency select picks one internal oscillator
  always_comb begin
    if (ircf >= IRCF_HF_MIN)      int_src = SRC_HF;
    else if (ircf >= IRCF_MF_MIN) int_src = SRC_MF;
    else                          int_src = SRC_LF;
    if (scs[1] || fosc == FOSC_INT) tgt_src = int_src;
    else                            tgt_src = SRC_EXT;
  end

  // level of a given source
  function automatic logic lvl_of(input scss_src_t s, input logic e, input logic l,
                                  input logic m, input logic h);
    logic r;
    r = e;
    unique case (s)
      SRC_EXT: r = e;
      SRC_LF:  r = l;
      SRC_MF:  r = m;
      SRC_HF:  r = h;
    endcase
    return r;
  endfunction

  // readiness of a given source, external is always there
  function automatic logic rdy_of(input scss_src_t s, input logic l, input logic m,
                                  input logic h);
    logic r;
    r = 1'b1;
    unique case (s)
      SRC_EXT: r = 1'b1;
      SRC_LF:  r = l;
      SRC_MF:  r = m;
      SRC_HF:  r = h;
    endcase
    return r;
  endfunction

  // ==========================================================
  // internal oscillators; high clock is the mid one times 32
  assign mf_half = HALF_W'(MF_HALF_CYC) + {{(HALF_W-6){trim[5]}}, trim};
  assign hf_half = mf_half >> PLL_SHIFT;

  scss_osc #(.START_CYC(LF_START), .HW(HALF_W)) u_lf (
    .i_clk(I_REF_CLK), .i_rst(I_RESET), .i_en(osc_en[0]),
    .i_half(HALF_W'(LF_HALF_CYC)), .o_ready(lf_rdy), .o_lvl(lf_lvl)
  );
  scss_osc #(.START_CYC(MF_START), .HW(HALF_W)) u_mf (
    .i_clk(I_REF_CLK), .i_rst(I_RESET), .i_en(osc_en[1]),
    .i_half(mf_half), .o_ready(mf_rdy), .o_lvl(mf_lvl)
  );
  scss_osc #(.START_CYC(HF_START), .HW(HALF_W)) u_hf (
    .i_clk(I_REF_CLK), .i_rst(I_RESET), .i_en(osc_en[2] && mf_rdy),
    .i_half(hf_half), .o_ready(hf_rdy), .o_lvl(hf_lvl)
  );

  // ==========================================================
  // oscillator power: the running and the pending source, plus the mid one whenever the high clock runs or is pending
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      osc_en <= 3'h0;
    end else begin
      osc_en[0] <= (cur_src == SRC_LF) || (state != ST_IDLE && nxt_src == SRC_LF);
      osc_en[2] <= (cur_src == SRC_HF) || (state != ST_IDLE && nxt_src == SRC_HF);
      osc_en[1] <= (cur_src == SRC_MF) || (state != ST_IDLE && nxt_src == SRC_MF)
                || (cur_src == SRC_HF) || (state != ST_IDLE && nxt_src == SRC_HF);
    end
  end

  scss_switch u_sw (
    .i_clk(I_REF_CLK), .i_rst(I_RESET), .i_start(sw_start),
    .i_cur_lvl(lvl_of(cur_src, ext_lvl, lf_lvl, mf_lvl, hf_lvl)),
    .i_new_lvl(lvl_of(nxt_src, ext_lvl, lf_lvl, mf_lvl, hf_lvl)),
    .o_hold(sw_hold), .o_done(sw_done)
  );

  // ==========================================================
  // switch sequencer, one sequence at a time
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state    <= ST_INIT;
      cur_src  <= SRC_EXT;
      nxt_src  <= SRC_EXT;
      stat_src <= SRC_EXT;
      run      <= 1'b0;
      sw_start <= 1'b0;
    end else begin
      sw_start <= 1'b0;
      unique case (state)
        ST_INIT: begin
          if (cfg_done) begin
            nxt_src <= tgt_src;
            state   <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          if (rdy_of(nxt_src, lf_rdy, mf_rdy, hf_rdy)) begin
            cur_src  <= nxt_src;
            stat_src <= nxt_src;
            run      <= 1'b1;
            state    <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (tgt_src != cur_src) begin
            nxt_src <= tgt_src;
            if (rdy_of(tgt_src, lf_rdy, mf_rdy, hf_rdy)) begin
              sw_start <= 1'b1;
              state    <= ST_SWITCH;
            end else begin
              state <= ST_START;
            end
          end
        end
        ST_START: begin
          if (rdy_of(nxt_src, lf_rdy, mf_rdy, hf_rdy)) begin
            sw_start <= 1'b1;
            state    <= ST_SWITCH;
          end
        end
        ST_SWITCH: begin
          if (sw_done) begin
            cur_src  <= nxt_src;
            stat_src <= nxt_src;
            state    <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // system clock and pin functions
  // new source drives from the cycle the hold drops, before cur_src moves over
  assign next_sys  = run && !sw_hold
                  && lvl_of(sw_done ? nxt_src : cur_src, ext_lvl, lf_lvl, mf_lvl, hf_lvl);
  assign rc_or_int = (fosc == FOSC_RC) || (fosc == FOSC_INT);

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_SYS_CLK       <= 1'b0;
      O_CLOCK_INPUT_PIN_GPIO_EN <= 1'b0;
      O_OSCILLATOR_PIN_TWO_OUT      <= 1'b0;
      O_OSCILLATOR_PIN_TWO_OE       <= 1'b0;
      O_XTAL_EN       <= 1'b0;
      O_EC_POWER      <= EC_PWR_OFF;
      stat_rdy        <= 3'h0;
    end else begin
      O_SYS_CLK       <= next_sys;
      O_CLOCK_INPUT_PIN_GPIO_EN <= cfg_done && fosc == FOSC_INT;
      O_XTAL_EN       <= cfg_done && fosc <= FOSC_HS;
      if (cfg_done && rc_or_int && clock_output_pin_en) begin
        O_OSCILLATOR_PIN_TWO_OUT <= next_sys;
        O_OSCILLATOR_PIN_TWO_OE  <= 1'b1;
      end else if (cfg_done && fosc >= FOSC_RC) begin
        O_OSCILLATOR_PIN_TWO_OUT <= I_OSCILLATOR_PIN_TWO_GPIO_OUT;
        O_OSCILLATOR_PIN_TWO_OE  <= I_OSCILLATOR_PIN_TWO_GPIO_OE;
      end else begin
        O_OSCILLATOR_PIN_TWO_OUT <= 1'b0;
        O_OSCILLATOR_PIN_TWO_OE  <= 1'b0;
      end
      unique case (fosc)
        FOSC_ECH: O_EC_POWER <= EC_PWR_HIGH;
        FOSC_ECM: O_EC_POWER <= EC_PWR_MED;
        FOSC_ECL: O_EC_POWER <= EC_PWR_LOW;
        default:  O_EC_POWER <= EC_PWR_OFF;
      endcase
      stat_rdy <= {hf_rdy, mf_rdy, lf_rdy};
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after request, write at the ack edge
  assign wb_req = I_WB_CYC && I_WB_STB;

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      O_WB_ACK <= wb_req && !O_WB_ACK;
      O_WB_DAT <= 32'h0;
      if (wb_req && !O_WB_ACK && !I_WB_WE) begin
        unique case (I_WB_ADR)
          ADR_CTRL: O_WB_DAT <= {25'h0, ircf, 1'b0, scs};
          ADR_STAT: O_WB_DAT <= {25'h0, state != ST_IDLE, stat_src, 1'b0, stat_rdy};
          ADR_TRIM: O_WB_DAT <= {26'h0, trim};
          ADR_CFG:  O_WB_DAT <= {28'h0, clock_output_pin_en, fosc};
          default:  O_WB_DAT <= 32'h0;
        endcase
      end
    end
  end

  // control and trim registers
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      scs  <= SCS_RST;
      ircf <= IRCF_RST;
      trim <= TRIM_RST;
    end else if (wb_req && O_WB_ACK && I_WB_WE && I_WB_SEL[0]) begin
      if (I_WB_ADR == ADR_CTRL) begin
        scs  <= I_WB_DAT[CTRL_SCS_LSB +: 2];
        ircf <= I_WB_DAT[CTRL_IRCF_LSB +: 4];
      end
      if (I_WB_ADR == ADR_TRIM) trim <= I_WB_DAT[5:0];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  a_clock_input_pin_release: assert property ($past(cfg_done) |->
    O_CLOCK_INPUT_PIN_GPIO_EN == (fosc == FOSC_INT)) else $error("clock input pin use wrong");
  a_oscillator_pin_two_clock_output_pin: assert property ($past(cfg_done) && rc_or_int && clock_output_pin_en |=>
    O_OSCILLATOR_PIN_TWO_OE) else $error("clock output not driven");
  a_xtal_decode: assert property ($past(cfg_done) |->
    O_XTAL_EN == (fosc <= FOSC_HS)) else $error("crystal mode decode wrong");
  a_boot_default: assert property ($rose(run) |-> cur_src == $past(nxt_src))
    else $error("boot source not the configured one");
  a_start_delay: assert property (state == ST_START && !rdy_of(nxt_src, lf_rdy, mf_rdy,
    hf_rdy) |=> !sw_start) else $error("switch began before start-up");
  a_hold_low: assert property (sw_hold |=> !O_SYS_CLK)
    else $error("system clock not held low");
  a_status_late: assert property (state == ST_SWITCH && !sw_done |=> $stable(stat_src))
    else $error("status changed before switch end");
  a_one_switch: assert property (state == ST_SWITCH && !sw_done |=> $stable(nxt_src))
    else $error("target changed mid switch");
  a_hf_from_mf: assert property (hf_rdy |-> mf_rdy && $past(osc_en[1]))
    else $error("high clock without mid oscillator");
  a_status_rdy: assert property (##1 stat_rdy == $past({hf_rdy, mf_rdy, lf_rdy}))
    else $error("status does not follow oscillators");
  a_wb_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held over two cycles");

  c_switch_done: cover property (state == ST_SWITCH ##1 state == ST_IDLE);
  c_startup_path: cover property (state == ST_START ##[1:1000] sw_start);
  c_boot_internal: cover property ($rose(run) && cur_src != SRC_EXT);

endmodule // scss_top

/* verif/scss_ext_clk_model.sv */
// far-side clock driver on the clock input pin
// assumes the bench raises i_run only in external clock modes
`timescale 1ns/1ps
module scss_ext_clk_model #(
  parameter realtime HALF_NS = 40.0
) (
  input  wire logic i_run,
  output logic      o_clk
);
  // ==========================================================
  // free square wave, still and low when not running
  initial o_clk = 1'b0;
  // drives pin one only, pin two stays free
  always begin
    #(HALF_NS);
    if (i_run) begin
      o_clk = ~o_clk;
    end else begin
      o_clk = 1'b0;
    end
  end
endmodule // scss_ext_clk_model

/* verif/system_clock_source_select_test.sv */
// self-checking bench for the clock source selector
// assumes the wishbone slave acks one cycle after a request
`timescale 1ns/1ps
module system_clock_source_select_test;
  import scss_pkg::*;
  logic I_REF_CLK = 0, I_RESET = 1, cyc = 0, stb = 0, we = 0, run = 0;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rd, O_WB_DAT;
  logic [2:0] cfg = 0;
  logic clken = 0, O_WB_ACK, clock_input_pin, sys_clk, xtal, gpio_en, o2_out, o2_oe;
  logic [1:0] ec_pwr;
  logic gpio_out = 0, gpio_oe = 0, clko;
  int miscompares = 0, check_count = 0, cycles = 0, per;
  always #2 I_REF_CLK = ~I_REF_CLK;
  // ==========================================================
  // design and far side
  scss_top #(.HF_START(4), .MF_START(4), .LF_START(4)) uut (
    .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_OSC_CONFIG(cfg),
    .I_CLOCK_OUTPUT_PIN_PIN_EN(clken), .I_CLOCK_INPUT_PIN(clock_input_pin), .I_OSCILLATOR_PIN_TWO_GPIO_OUT(gpio_out),
    .I_OSCILLATOR_PIN_TWO_GPIO_OE(gpio_oe), .O_SYS_CLK(sys_clk), .O_CLOCK_INPUT_PIN_GPIO_EN(gpio_en),
    .O_OSCILLATOR_PIN_TWO_OUT(o2_out), .O_OSCILLATOR_PIN_TWO_OE(o2_oe), .O_XTAL_EN(xtal), .O_EC_POWER(ec_pwr));
  scss_ext_clk_model #(.HALF_NS(40.0)) ext (.i_run(run), .o_clk(clock_input_pin));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic wishbone cycle, held until ack is seen at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge I_REF_CLK);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge I_REF_CLK);
      n++;
    end while (O_WB_ACK !== 1'b1);
    rd = O_WB_DAT;
    chk("ack_wait", 2, n);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic rst(input logic [2:0] c, input logic e);
    @(posedge I_REF_CLK);
    I_RESET <= 1;
    cfg <= c;
    clken <= e;
    repeat (8) @(posedge I_REF_CLK);
    I_RESET <= 0;
    repeat (3) @(posedge I_REF_CLK);
  endtask
  // wait until idle on the given source
  task automatic poll(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      bus(0, ADR_STAT, 0);
      n++;
    end while (rd[6:4] !== {1'b0, s} && n < 6000);
    // let the ready bits follow the source change
    repeat (4) @(posedge I_REF_CLK);
    bus(0, ADR_STAT, 0);
    chk("source", {1'b0, s}, rd[6:4]);
  endtask
  // cycles between two rising edges of the system clock
  task automatic measure();
    int n;
    n = 0;
    while (sys_clk !== 1'b0 && n < 20000) begin
      @(negedge I_REF_CLK);
      n++;
    end
    while (sys_clk !== 1'b1 && n < 20000) begin
      @(negedge I_REF_CLK);
      n++;
    end
    per = 0;
    do begin
      @(negedge I_REF_CLK);
      per++;
    end while (sys_clk === 1'b1 && per < 20000);
    do begin
      @(negedge I_REF_CLK);
      per++;
    end while (sys_clk !== 1'b1 && per < 20000);
  endtask
  task automatic conclude();
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge I_REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      conclude();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    for (int i = 0; i < 16; i++) begin
      gpio_out <= i[1];
      gpio_oe <= i[0];
      rst(i[2:0], i[3]);
      clko = (i[2:0] == 3'b011 || i[2:0] == 3'b100) && i[3];
      chk("xtal", (i[2:0] <= 3'b010), xtal);
      chk("ecpwr", (i[2] && i[1:0] != 2'b00) ? i[1:0] : 0, ec_pwr);
      chk("clock_input_pin_gpio", (i[2:0] == 3'b100), gpio_en);
      chk("oscillator_pin_two_oe", clko ? 1 : (i[2:0] >= 3'b011) && i[0], o2_oe);
      if (!clko) chk("oscillator_pin_two_out", (i[2:0] >= 3'b011) && i[1], o2_out);
    end
    rst(3'b100, 1);
    poll(SRC_MF);
    chk("stat_osc", 3'b010, rd[2:0]);
    bus(0, ADR_CTRL, 0);
    chk("ctrl_rst", 32'h38, rd);
    bus(0, ADR_CFG, 0);
    chk("cfg", 32'h0c, rd);
    bus(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    measure();
    chk("mid_per", 500, per);
    chk("clock_output_pin", 1, o2_out);
    bus(1, ADR_TRIM, 32'h06);
    bus(0, ADR_TRIM, 0);
    chk("trim", 32'h06, rd);
    measure();
    measure();
    chk("mid_trim", 512, per);
    bus(1, ADR_CTRL, 32'h42);
    poll(SRC_HF);
    chk("stat_hf", 3'b110, rd[2:0]);
    measure();
    chk("hf_per", 16, per);
    bus(1, ADR_CTRL, 32'h4a);
    bus(0, ADR_STAT, 0);
    chk("same_src", 3'b011, rd[6:4]);
    bus(1, ADR_CTRL, 32'h02);
    poll(SRC_LF);
    chk("stat_lf", 3'b001, rd[2:0]);
    bus(1, ADR_CTRL, 32'h42);
    bus(1, ADR_CTRL, 32'h12);
    poll(SRC_MF);
    chk("stat_mf", 3'b010, rd[2:0]);
    run <= 1;
    rst(3'b111, 0);
    poll(SRC_EXT);
    measure();
    chk("ext_per", 1, (per >= 19 && per <= 21));
    conclude();
  end
endmodule // system_clock_source_select_test
